// File: hw/bws_map.svh
// constants of the bit and word shift register unit
// What this block does
// - a rising shift pulse with a valid span and no word shift moves every span bit one place toward the end word and loads data into bit 00 of the first word.
// - the span runs from the first word as its low word up to the end word as its high word, all words between included.
// - when first and end word are the same word the bit shifter acts as one 16-bit register.
// - while clear is high the span is held at zero and shift pulses are ignored.
// - the bit shifter never alters the error, carry or equal flags.
// - with its enable low the word shifter does nothing, with it high each execution on a valid span while clear is low moves the span up by whole words.
// - a word shift writes zero into the first word and drops the old end word.
// - a word shift raises the error flag when the bounds lie in different areas or first is above end.
`ifndef BWS_MAP_SVH
`define BWS_MAP_SVH
`define BWS_WORD_W      16
`define BWS_WORD_MSB    15
`define BWS_ADDR_W      5
`define BWS_ADDR_MSB    4
`define BWS_AREA_BIT    4
`define BWS_WORDS       32
`define BWS_WORD_ZERO   16'h0000
`define BWS_ADDR_ZERO   5'h00
`define BWS_SYNC_W      3
`define BWS_PIN_DATA    2
`define BWS_PIN_PULSE   1
`define BWS_PIN_CLEAR   0
`endif

// File: hw/bws_pkg.sv
// types of the bit and word shift register unit
`include "bws_map.svh"
package bws_pkg;
    typedef logic [`BWS_WORD_MSB:0] bws_word_t;
    typedef logic [`BWS_ADDR_MSB:0] bws_addr_t;

    // span bounds given by the controller
    typedef struct packed {
        bws_addr_t first;
        bws_addr_t last;
    } bws_span_s;

    // status flags; the carry and equal flags are tied to zero by this unit
    typedef struct packed {
        logic err;
        logic carry;
        logic equal;
    } bws_flags_s;
endpackage

// File: hw/bws_shift_unit.sv
// word memory with bit shift and word shift operations
`timescale 1ns/1ps
`include "bws_map.svh"
module bws_shift_unit
(
    // clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   nrst_i,
    // bit shift pins, asynchronous to sys_clk_i
    input  wire logic                   shift_data_i,
    input  wire logic                   shift_pulse_i,
    input  wire logic                   shift_clear_i,
    // span bounds, same clock
    input  wire bws_pkg::bws_span_s     span_i,
    // word shift request, same clock
    input  wire logic                   word_shift_en_i,
    input  wire logic                   word_shift_exec_i,
    // memory load and readback, same clock
    input  wire logic                   wr_en_i,
    input  wire bws_pkg::bws_addr_t     wr_addr_i,
    input  wire bws_pkg::bws_word_t     wr_data_i,
    input  wire bws_pkg::bws_addr_t     rd_addr_i,
    output bws_pkg::bws_word_t          rd_data_o,
    // status
    output bws_pkg::bws_flags_s         flags_o,
    output logic                        bit_shift_done_o,
    output logic                        word_shift_done_o
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation and pulse edge

    logic [`BWS_SYNC_W-1:0] pins_raw;
    logic [`BWS_SYNC_W-1:0] pins_sync;
    logic                   data_s;
    logic                   pulse_s;
    logic                   clear_s;
    logic                   pulse_prev_r;
    logic                   pulse_rise;

    bws_sync u_sync
    (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .async_i   (pins_raw),
        .sync_o    (pins_sync)
    );

    // one bus through the synchroniser keeps data aligned with its pulse
    assign pins_raw[`BWS_PIN_DATA]  = shift_data_i;
    assign pins_raw[`BWS_PIN_PULSE] = shift_pulse_i;
    assign pins_raw[`BWS_PIN_CLEAR] = shift_clear_i;

    assign data_s  = pins_sync[`BWS_PIN_DATA];
    assign pulse_s = pins_sync[`BWS_PIN_PULSE];
    assign clear_s = pins_sync[`BWS_PIN_CLEAR];

    // previous level tracked even during clear, so a pulse held over clear gives no shift
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pulse_prev_r <= 1'b0;
        else
            pulse_prev_r <= pulse_s;
    end

    assign pulse_rise = pulse_s & ~pulse_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // span decode

    logic area_match;
    logic order_ok;
    logic span_ok;
    logic word_shift_go;
    logic do_clear;
    logic do_word;
    logic do_bit;
    logic any_op;

    // the bit shifter trusts the controller for sane bounds, so a bad span
    // only stops it; raising the flag is left to the word shifter
    assign area_match = (span_i.first[`BWS_AREA_BIT] == span_i.last[`BWS_AREA_BIT]);
    assign order_ok   = (span_i.first <= span_i.last);
    assign span_ok    = area_match & order_ok;

    // clear first, then a word shift, then a bit shift; a coincident pulse is lost
    assign word_shift_go = word_shift_en_i & word_shift_exec_i;
    assign do_clear      = clear_s;
    assign do_word       = ~do_clear & word_shift_go & span_ok;
    assign do_bit        = ~do_clear & ~word_shift_go & pulse_rise & span_ok;
    // a load in the same cycle as any operation is dropped rather than merged
    assign any_op        = do_clear | do_word | do_bit;

    ////////////////////////////////////////////////////////////////////////////
    // word memory and its next values

    bws_pkg::bws_word_t mem_r [`BWS_WORDS];

    genvar gi;
    generate
        for (gi = 0; gi < `BWS_WORDS; gi++)
        begin : g_word
            logic               in_span;
            logic               is_first;
            logic               wr_hit;
            logic               carry_in;
            bws_pkg::bws_addr_t idx;
            bws_pkg::bws_word_t below;
            bws_pkg::bws_word_t shifted;
            bws_pkg::bws_word_t moved;
            bws_pkg::bws_word_t word_nxt;

            assign idx      = bws_pkg::bws_addr_t'(gi);
            assign in_span  = (idx >= span_i.first) && (idx <= span_i.last);
            assign is_first = (idx == span_i.first);
            assign wr_hit   = wr_en_i && (wr_addr_i == idx) && !any_op;
            // the first word takes no neighbour, so gi-1 is never used there
            if (gi == 0)
            begin : g_bottom
                assign below = `BWS_WORD_ZERO;
            end
            else
            begin : g_upper
                assign below = mem_r[gi-1];
            end
            assign carry_in = is_first ? data_s : below[`BWS_WORD_MSB];
            // the end word's top bit has no higher word and is dropped
            assign shifted  = {mem_r[gi][`BWS_WORD_MSB-1:0], carry_in};
            assign moved    = is_first ? `BWS_WORD_ZERO : below;

            always_comb
            begin
                word_nxt = mem_r[gi];
                if (in_span && do_clear)
                begin
                    word_nxt = `BWS_WORD_ZERO;
                end
                else if (in_span && do_word)
                begin
                    word_nxt = moved;
                end
                else if (in_span && do_bit)
                begin
                    word_nxt = shifted;
                end
                else if (wr_hit)
                begin
                    word_nxt = wr_data_i;
                end
            end

            always_ff @(posedge sys_clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    mem_r[gi] <= `BWS_WORD_ZERO;
                end
                else
                begin
                    mem_r[gi] <= word_nxt;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // readback

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rd_data_o <= `BWS_WORD_ZERO;
        else
            rd_data_o <= mem_r[rd_addr_i];
    end

    ////////////////////////////////////////////////////////////////////////////
    // flags: only a word shift execution touches the error flag

    logic err_r;

    // replaced by every execution with the enable high; a level, never sticky
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            err_r <= 1'b0;
        end
        else if (word_shift_go)
        begin
            err_r <= ~span_ok;
        end
    end

    // neither shifter owns carry or equal, so both rest at zero
    assign flags_o.err   = err_r;
    assign flags_o.carry = 1'b0;
    assign flags_o.equal = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // completion strobes: one cycle per applied shift, a refused request leaves them low

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            bit_shift_done_o <= 1'b0;
        end
        else
        begin
            bit_shift_done_o <= do_bit;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            word_shift_done_o <= 1'b0;
        end
        else
        begin
            word_shift_done_o <= do_word;
        end
    end

endmodule // bws_shift_unit

// File: hw/bws_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`include "bws_map.svh"
module bws_sync
(
    // clock and reset
    input  wire logic                      sys_clk_i,
    input  wire logic                      nrst_i,
    // pins in, synchronised out
    input  wire logic [`BWS_SYNC_W-1:0]    async_i,
    output logic      [`BWS_SYNC_W-1:0]    sync_o
);
    logic [`BWS_SYNC_W-1:0] meta_r;

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            meta_r <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule // bws_sync

// File: verif/bws_ctrl_model.sv
// controller-side model driving the bit shift pins
`timescale 1ns/1ps
module bws_ctrl_model
(
    // clock
    input wire logic sys_clk_i,
    // pins toward the unit
    output logic     data_o,
    output logic     pulse_o,
    output logic     clear_o
);
    initial {data_o, pulse_o, clear_o} = 3'h0;
    // called at a falling edge; data is not held once the pulse drops
    task automatic strobe(input logic d, input int hi, input int gap);
        data_o = d;
        pulse_o = 1'b1;
        repeat (hi) @(negedge sys_clk_i);
        pulse_o = 1'b0;
        data_o = ~d;
        repeat (gap) @(negedge sys_clk_i);
    endtask
    // clear is a level: it stays where it is put until the next call
    task automatic set_clear(input logic c);
        clear_o = c;
    endtask
endmodule // bws_ctrl_model

// File: verif/bws_properties.sv
// port checker of the shift unit, bound below
`timescale 1ns/1ps
module bws_properties
(
    // watched ports
    input wire logic                sys_clk_i,
    input wire logic                nrst_i,
    input wire logic                shift_pulse_i,
    input wire logic                shift_clear_i,
    input wire bws_pkg::bws_span_s  span_i,
    input wire logic                word_shift_en_i,
    input wire logic                word_shift_exec_i,
    input wire bws_pkg::bws_flags_s flags_o,
    input wire logic                bit_shift_done_o,
    input wire logic                word_shift_done_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    wire go = word_shift_en_i && word_shift_exec_i;
    wire ok = span_i.first[4] == span_i.last[4] && span_i.first <= span_i.last;
    // clear reaches the core two flops late, so look three samples back
    sequence s_calm; (!shift_clear_i)[*3]; endsequence
    sequence s_req; s_calm ##0 (go && ok); endsequence
    AST_WS_DONE: assert property (s_req |=> word_shift_done_o) else $error("no word done");
    AST_ERR_SET: assert property (go && !ok |=> flags_o.err) else $error("err low");
    AST_WS_IDLE: assert property (!go |=> !word_shift_done_o) else $error("stray done");
    AST_ERR_HOLD: assert property (!go |=> $stable(flags_o.err)) else $error("err moved");
    AST_FLAGS: assert property (!flags_o.carry && !flags_o.equal) else $error("flag set");
    AST_ONE_SHOT: assert property (bit_shift_done_o |=> !bit_shift_done_o) else $error("long");
    AST_BS_CAUSE: assert property (bit_shift_done_o |-> $past(shift_pulse_i, 3)) else $error("no pulse");
    AST_CLR: assert property (shift_clear_i[*6] |-> !bit_shift_done_o) else $error("shift in clear");
endmodule // bws_properties
bind bws_shift_unit bws_properties u_props (.sys_clk_i, .nrst_i, .shift_pulse_i, .shift_clear_i,
    .span_i, .word_shift_en_i, .word_shift_exec_i, .flags_o, .bit_shift_done_o, .word_shift_done_o);

// File: verif/testbench.sv
// self-checking bench of the shift unit against a word model
`timescale 1ns/1ps
module testbench;
    logic                sys_clk_i, nrst_i, shift_data_i, shift_pulse_i, shift_clear_i, err_e;
    logic                word_shift_en_i, word_shift_exec_i, wr_en_i, bit_shift_done_o;
    logic                word_shift_done_o;
    bws_pkg::bws_span_s  span_i;
    bws_pkg::bws_addr_t  wr_addr_i, rd_addr_i;
    bws_pkg::bws_word_t  wr_data_i, rd_data_o, m [32];
    bws_pkg::bws_flags_s flags_o;
    int                  miscompares = 0, checks = 0, nb = 0, nw = 0, eb = 0, ew = 0, seed = 65;
    bws_shift_unit u_dut (.sys_clk_i, .nrst_i, .shift_data_i, .shift_pulse_i, .shift_clear_i,
        .span_i, .word_shift_en_i, .word_shift_exec_i, .wr_en_i, .wr_addr_i, .wr_data_i,
        .rd_addr_i, .rd_data_o, .flags_o, .bit_shift_done_o, .word_shift_done_o);
    bws_ctrl_model u_ctrl (.sys_clk_i, .data_o(shift_data_i), .pulse_o(shift_pulse_i),
        .clear_o(shift_clear_i));
    initial
    begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i)
    begin
        nb += (bit_shift_done_o === 1'b1);
        nw += (word_shift_done_o === 1'b1);
    end
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // reads every word, so a write outside the span shows up too
    task automatic cmp_all(input string t);
        for (int i = 0; i < 32; i++)
        begin
            rd_addr_i = 5'(i);
            @(negedge sys_clk_i);
            chk("word", rd_data_o, m[i]);
        end
        chk("word done count", 16'(nw), 16'(ew));
        $display("test %s done", t);
    endtask
    task automatic bshift(input int hi);
        int f;
        int l;
        logic d;
        f = span_i.first;
        l = span_i.last;
        d = 1'($random(seed));
        u_ctrl.strobe(d, hi, 4);
        for (int i = l; i > f; i--)
            m[i] = {m[i][14:0], m[i-1][15]};
        m[f] = {m[f][14:0], d};
        eb++;
        chk("bit done count", 16'(nb), 16'(eb));
        rd_addr_i = 5'(f);
        @(negedge sys_clk_i);
        chk("first word", rd_data_o, m[f]);
    endtask
    task automatic wshift(input logic en);
        int f;
        int l;
        f = span_i.first;
        l = span_i.last;
        word_shift_en_i = en;
        word_shift_exec_i = 1'b1;
        @(negedge sys_clk_i);
        word_shift_exec_i = 1'b0;
        @(negedge sys_clk_i);
        if (en)
            err_e = span_i.first[4] != span_i.last[4] || f > l;
        if (en && !err_e)
        begin
            for (int i = l; i > f; i--)
                m[i] = m[i-1];
            m[f] = 16'h0000;
            ew++;
        end
        chk("error flag", 16'(flags_o.err), 16'(err_e));
        rd_addr_i = 5'(f);
        @(negedge sys_clk_i);
        chk("first word", rd_data_o, m[f]);
    endtask
    initial
    begin
        #500000;
        miscompares++;
        conclude();
    end
    initial
    begin
        nrst_i = 1'b0;
        err_e = 1'b0;
        {word_shift_en_i, word_shift_exec_i, wr_en_i, wr_addr_i, wr_data_i, rd_addr_i, span_i} = '0;
        repeat (16) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        wr_en_i = 1'b1;
        for (int i = 0; i < 32; i++)
        begin
            m[i] = 16'($random(seed));
            wr_addr_i = 5'(i);
            wr_data_i = m[i];
            @(negedge sys_clk_i);
        end
        wr_en_i = 1'b0;
        span_i = {5'h03, 5'h05};
        for (int i = 0; i < 20; i++)
            bshift(i % 7 + 2);
        cmp_all("chain");
        span_i = {5'h14, 5'h14};
        repeat (17) bshift(2);
        cmp_all("single");
        span_i = {5'h03, 5'h05};
        repeat (2) wshift(1'b1);
        wshift(1'b0);
        span_i = {5'h0e, 5'h11};
        wshift(1'b1);
        span_i = {5'h06, 5'h04};
        wshift(1'b1);
        wshift(1'b0);
        span_i = {5'h03, 5'h05};
        bshift(3);
        chk("flags", 16'(flags_o), 16'({err_e, 2'h0}));
        wshift(1'b1);
        cmp_all("word");
        u_ctrl.set_clear(1'b1);
        repeat (4) @(negedge sys_clk_i);
        u_ctrl.strobe(1'b1, 2, 4);
        for (int i = 3; i <= 5; i++)
            m[i] = 16'h0000;
        u_ctrl.set_clear(1'b0);
        repeat (3) @(negedge sys_clk_i);
        bshift(2);
        cmp_all("clear");
        conclude();
    end
endmodule // testbench
